// file: hdl/sfsat_tx_end.sv
// sfsat_tx_end: frame builder of the serial output: buffering, test
// patterns, scrambling, alignment-monitor substitution and preamble.
// assumes an 8b/10b encoder and serialiser follow the link symbols.
`timescale 1ns/1ns
module sfsat_tx_end
    import sfsat_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_sample,
    input  wire logic        i_sample_valid,
    output logic             o_sample_ready,
    input  wire logic        i_scramble_enable,
    input  wire logic        i_align_monitor_enable,
    input  wire logic        i_rate_range_sel_lo,
    input  wire logic        i_rate_range_sel_hi,
    input  wire logic        i_test_pattern_sel_lo,
    input  wire logic        i_test_pattern_sel_hi,
    output logic [1:0]       o_pll_range,
    sfsat_link_if.tx_mp      link
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [6:0] pin_meta_q;
    logic [6:0] pin_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pin_meta_q <= 7'h00;
            pin_q      <= 7'h00;
        end
        else
        begin
            pin_meta_q <= {link.sync_req, i_scramble_enable,
                           i_align_monitor_enable, i_rate_range_sel_hi,
                           i_rate_range_sel_lo, i_test_pattern_sel_hi,
                           i_test_pattern_sel_lo};
            pin_q      <= pin_meta_q;
        end
    end

    logic       sync_s;
    logic       scr_en;
    logic       fam_en;
    sfsat_pat_t pat_sel;
    assign sync_s  = pin_q[6];
    assign scr_en  = pin_q[5];
    assign fam_en  = pin_q[4];
    assign pat_sel = sfsat_pat_t'(pin_q[1:0]);

    // ****************************************************************
    // pll range
    // ****************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_pll_range <= SFSAT_RATE_20_35;
        else if (!pin_q[3])
            o_pll_range <= SFSAT_RATE_20_35;
        else if (!pin_q[2])
            o_pll_range <= SFSAT_RATE_30_65;
        else
            o_pll_range <= SFSAT_RATE_60_80;
    end

    // ****************************************************************
    // sync request / preamble
    // ****************************************************************
    logic [1:0] sync_cnt_q;
    logic       preamble;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            sync_cnt_q <= 2'h0;
        else if (!sync_s)
            sync_cnt_q <= 2'h0;
        else if (sync_cnt_q != SYNC_MIN_CYC)
            sync_cnt_q <= sync_cnt_q + 2'h1;
    end

    // a one-clock glitch on the request never starts a preamble; each
    // clock is a frame, so release takes effect on the next frame
    assign preamble = sync_s && (sync_cnt_q != 2'h0);

    // ****************************************************************
    // two-entry sample buffer
    // ****************************************************************
    logic [15:0] buf_mem [2];
    logic        wr_ptr_q;
    logic        rd_ptr_q;
    logic [1:0]  count_q;
    logic [1:0]  count_d;
    logic        push;
    logic        pop;
    logic        send;

    assign send = link.rx_ready || preamble;
    assign push = i_sample_valid && o_sample_ready;
    assign pop  = (count_q != 2'h0) && !preamble && link.rx_ready
                  && (pat_sel == SFSAT_PAT_DATA);

    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
            count_d = count_q + 2'h1;
        else if (pop && !push)
            count_d = count_q - 2'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_ptr_q       <= 1'b0;
            rd_ptr_q       <= 1'b0;
            count_q        <= 2'h0;
            o_sample_ready <= 1'b1;
        end
        else
        begin
            if (push)
                wr_ptr_q <= !wr_ptr_q;
            if (pop)
                rd_ptr_q <= !rd_ptr_q;
            count_q        <= count_d;
            o_sample_ready <= (count_d != 2'h2);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            buf_mem[wr_ptr_q] <= i_sample;
    end

    // ****************************************************************
    // scrambler and pattern generators
    // ****************************************************************
    logic [14:0] scr_q;
    logic [14:0] prbs15_q;
    logic [10:0] prbs11_q;
    logic [30:0] scr_res;
    logic [15:0] raw_word;
    logic [15:0] data_word;
    logic [15:0] prbs15_word;
    logic [15:0] prbs11_word;
    logic [14:0] prbs15_d;
    logic [10:0] prbs11_d;

    assign raw_word  = buf_mem[rd_ptr_q];
    assign scr_res   = sfsat_scramble(raw_word, scr_q);
    assign data_word = scr_en ? scr_res[15:0] : raw_word;

    // generators step sixteen bits, one per bit of the frame
    always_comb
    begin
        prbs15_d = prbs15_q;
        prbs11_d = prbs11_q;
        for (int i = 15; i >= 0; i--)
        begin
            prbs15_word[i] = prbs15_d[14] ^ prbs15_d[13];
            prbs15_d       = {prbs15_d[13:0], prbs15_word[i]};
            prbs11_word[i] = prbs11_d[10] ^ prbs11_d[8];
            prbs11_d       = {prbs11_d[9:0], prbs11_word[i]};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            scr_q <= SCR_SEED;
        else if (pop && scr_en)
            scr_q <= scr_res[30:16];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prbs15_q <= PRBS15_SEED;
            prbs11_q <= PRBS11_SEED;
        end
        else if (send && !preamble)
        begin
            if (pat_sel == SFSAT_PAT_PRBS15)
                prbs15_q <= prbs15_d;
            if (pat_sel == SFSAT_PAT_PRBS11)
                prbs11_q <= prbs11_d;
        end
    end

    // ****************************************************************
    // alignment monitor
    // ****************************************************************
    logic [7:0] prev2_q;
    logic       prev_k_q;
    logic       prev_ok_q;
    logic       sub;

    always_comb
    begin
        sub = 1'b0;
        if (fam_en && !scr_en)
            sub = prev_ok_q && (data_word[7:0] == prev2_q)
                  && !prev_k_q;
        else if (fam_en && scr_en)
            sub = (data_word[7:0] == SYM_D28_7);
    end

    // history covers data frames only; any other frame breaks it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prev2_q   <= 8'h00;
            prev_k_q  <= 1'b0;
            prev_ok_q <= 1'b0;
        end
        else if (pop)
        begin
            prev2_q   <= data_word[7:0];
            prev_k_q  <= sub;
            prev_ok_q <= 1'b1;
        end
        // idle slots keep it: the receiver restores from its last word
        else if (preamble || (send && pat_sel != SFSAT_PAT_DATA))
            prev_ok_q <= 1'b0;
    end

    // ****************************************************************
    // frame output
    // ****************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            link.frame_valid <= 1'b0;
            link.oct1        <= 8'h00;
            link.k1          <= 1'b0;
            link.oct2        <= 8'h00;
            link.k2          <= 1'b0;
        end
        else if (preamble)
        begin
            link.frame_valid <= 1'b1;
            link.oct1        <= SYM_K28_5;
            link.k1          <= 1'b1;
            link.oct2        <= SYM_K28_5;
            link.k2          <= 1'b1;
        end
        else
        begin
            link.frame_valid <= pop || (send && pat_sel != SFSAT_PAT_DATA);
            link.k1          <= 1'b0;
            link.k2          <= 1'b0;
            case (pat_sel)
                SFSAT_PAT_DATA:
                begin
                    link.oct1 <= data_word[15:8];
                    link.oct2 <= sub ? SYM_K28_7 : data_word[7:0];
                    link.k2   <= sub;
                end
                SFSAT_PAT_D21_5:
                begin
                    link.oct1 <= SYM_D21_5;
                    link.oct2 <= SYM_D21_5;
                end
                SFSAT_PAT_PRBS11:
                begin
                    link.oct1 <= prbs11_word[15:8];
                    link.oct2 <= prbs11_word[7:0];
                end
                default:
                begin
                    link.oct1 <= prbs15_word[15:8];
                    link.oct2 <= prbs15_word[7:0];
                end
            endcase
        end
    end

endmodule // sfsat_tx_end

// file: include/sfsat_pkg.sv
// sfsat_pkg: constants, types and shared helpers for the serial frame
// scramble/align transmit end and its partner receive end.
// assumes one 25 MHz frame clock shared by both ends; one frame per clock.
package sfsat_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    // sync request must be seen on this many consecutive clocks
    localparam logic [1:0] SYNC_MIN_CYC = 2'h2;
    // consecutive comma frames the receiver wants before releasing
    localparam logic [2:0] PREAMBLE_NEED = 3'h4;

    // ****************************************************************
    // symbols (octet value before 8b/10b, k flag carried separately)
    // ****************************************************************
    localparam logic [7:0] SYM_K28_5 = 8'hBC;
    localparam logic [7:0] SYM_K28_7 = 8'hFC;
    localparam logic [7:0] SYM_D28_7 = 8'hFC;
    localparam logic [7:0] SYM_D21_5 = 8'hB5;

    // ****************************************************************
    // reset values of sequence generators
    // ****************************************************************
    localparam logic [14:0] SCR_SEED   = 15'h7FFF;
    localparam logic [14:0] PRBS15_SEED = 15'h7FFF;
    localparam logic [10:0] PRBS11_SEED = 11'h7FF;

    // ****************************************************************
    // codes of the select pins
    // ****************************************************************
    typedef enum logic [1:0] {
        SFSAT_PAT_DATA   = 2'h0,
        SFSAT_PAT_D21_5  = 2'h1,
        SFSAT_PAT_PRBS11 = 2'h2,
        SFSAT_PAT_PRBS15 = 2'h3
    } sfsat_pat_t;

    typedef enum logic [1:0] {
        SFSAT_RATE_20_35 = 2'h0,
        SFSAT_RATE_30_65 = 2'h1,
        SFSAT_RATE_60_80 = 2'h2
    } sfsat_rate_t;

    // ****************************************************************
    // 16-bit parallel 1 + x^14 + x^15, bit 15 handled first
    // ****************************************************************
    function automatic logic [30:0] sfsat_scramble(input logic [15:0] d,
                                                   input logic [14:0] st);
        logic [14:0] s;
        logic [15:0] o;
        logic        b;
        s = st;
        o = 16'h0000;
        for (int i = 15; i >= 0; i--)
        begin
            b    = d[i] ^ s[13] ^ s[14];
            o[i] = b;
            s    = {s[13:0], b};
        end
        return {s, o};
    endfunction

    // self-aligning: state is fed from the received line bits only
    function automatic logic [30:0] sfsat_descramble(input logic [15:0] d,
                                                     input logic [14:0] st);
        logic [14:0] s;
        logic [15:0] o;
        s = st;
        for (int i = 15; i >= 0; i--)
        begin
            o[i] = d[i] ^ s[13] ^ s[14];
            s    = {s[13:0], d[i]};
        end
        return {s, o};
    endfunction

endpackage

// file: include/sfsat_link_if.sv
// sfsat_link_if: one frame per clock, two symbols ahead of 8b/10b.
// assumes both ends run on the same frame clock; no clocking block.
`timescale 1ns/1ns
interface sfsat_link_if;
    logic       sync_req;
    logic       rx_ready;
    logic       frame_valid;
    logic [7:0] oct1;
    logic       k1;
    logic [7:0] oct2;
    logic       k2;

    modport tx_mp (
        input  sync_req,
        input  rx_ready,
        output frame_valid,
        output oct1,
        output k1,
        output oct2,
        output k2
    );

    modport rx_mp (
        output sync_req,
        output rx_ready,
        input  frame_valid,
        input  oct1,
        input  k1,
        input  oct2,
        input  k2
    );
endinterface

// file: hdl/sfsat_rx_end.sv
// sfsat_rx_end: partner end: sync request, frame tracking, K28.7
// restore and 16-bit self-aligning descrambling.
// assumes symbols arrive already decoded from 8b/10b, one pair a clock.
`timescale 1ns/1ns
module sfsat_rx_end
    import sfsat_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_scramble_enable,
    input  wire logic        i_align_monitor_enable,
    input  wire logic        i_resync,
    input  wire logic        i_user_ready,
    output logic [15:0]      o_sample,
    output logic             o_sample_valid,
    output logic             o_synced,
    sfsat_link_if.rx_mp      link
);

    typedef enum logic [1:0] {RX_HUNT, RX_WAIT, RX_RUN} sfsat_rx_state_t;

    // ****************************************************************
    // sync request
    // ****************************************************************
    sfsat_rx_state_t state_q;
    logic [2:0]      comma_cnt_q;
    logic            comma;

    assign comma = link.frame_valid && link.k1 && link.k2
                   && link.oct1 == SYM_K28_5 && link.oct2 == SYM_K28_5;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_q       <= RX_HUNT;
            comma_cnt_q   <= 3'h0;
            link.sync_req <= 1'b1;
            o_synced      <= 1'b0;
        end
        else
        begin
            case (state_q)
                RX_HUNT:
                begin
                    if (!comma)
                        comma_cnt_q <= 3'h0;
                    else if (comma_cnt_q == PREAMBLE_NEED - 3'h1)
                    begin
                        link.sync_req <= 1'b0;
                        state_q       <= RX_WAIT;
                    end
                    else
                        comma_cnt_q <= comma_cnt_q + 3'h1;
                end
                RX_WAIT:
                begin
                    // first slot without commas; a data frame there is kept
                    if (!comma)
                    begin
                        state_q  <= RX_RUN;
                        o_synced <= 1'b1;
                    end
                end
                RX_RUN:
                begin
                    // words in flight during resync are simply dropped
                    if (i_resync)
                    begin
                        state_q       <= RX_HUNT;
                        comma_cnt_q   <= 3'h0;
                        link.sync_req <= 1'b1;
                        o_synced      <= 1'b0;
                    end
                end
                default:
                    state_q <= RX_HUNT;
            endcase
        end
    end

    // ****************************************************************
    // frame boundary tracking
    // ****************************************************************
    logic       offs_q;
    logic [8:0] last2_q;
    logic [8:0] a1;
    logic [8:0] a2;
    logic       k7_first;
    logic       k7_seen_q;
    logic       take;

    assign a1       = offs_q ? last2_q : {link.k1, link.oct1};
    assign a2       = offs_q ? {link.k1, link.oct1} : {link.k2, link.oct2};
    assign k7_first = (a1 == {1'b1, SYM_K28_7});
    assign take     = link.frame_valid && !i_resync
                      && (state_q == RX_RUN
                          || (state_q == RX_WAIT && !comma));

    always_ff @(posedge i_clk)
    begin
        if (i_rst || state_q != RX_RUN)
        begin
            offs_q    <= 1'b0;
            k7_seen_q <= 1'b0;
            last2_q   <= 9'h000;
        end
        else if (link.frame_valid)
        begin
            last2_q   <= {link.k2, link.oct2};
            k7_seen_q <= i_align_monitor_enable && k7_first;
            if (i_align_monitor_enable && k7_first && k7_seen_q)
            begin
                offs_q    <= !offs_q;
                k7_seen_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // restore and descramble
    // ****************************************************************
    logic [7:0]  prev_d2_q;
    logic [7:0]  oct2_fix;
    logic [30:0] dsc_res;
    logic [14:0] dsc_q;
    logic [15:0] word;

    always_comb
    begin
        oct2_fix = a2[7:0];
        if (i_align_monitor_enable && a2 == {1'b1, SYM_K28_7})
            oct2_fix = i_scramble_enable ? SYM_D28_7
                                         : prev_d2_q;
    end

    assign dsc_res = sfsat_descramble({a1[7:0], oct2_fix}, dsc_q);
    assign word    = i_scramble_enable ? dsc_res[15:0]
                                       : {a1[7:0], oct2_fix};

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prev_d2_q <= 8'h00;
            dsc_q     <= SCR_SEED;
        end
        else if (take)
        begin
            prev_d2_q <= oct2_fix;
            // tracks the sender, whose state moves on scrambled frames only
            if (i_scramble_enable)
                dsc_q <= dsc_res[30:16];
        end
    end

    // ****************************************************************
    // user output
    // ****************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_sample       <= 16'h0000;
            o_sample_valid <= 1'b0;
            link.rx_ready  <= 1'b0;
        end
        else
        begin
            // ready lags the user by a clock: even a stall of a single
            // cycle lets the word in flight overwrite a held word
            link.rx_ready <= i_user_ready;
            if (take)
            begin
                o_sample       <= word;
                o_sample_valid <= 1'b1;
            end
            else if (i_user_ready)
                o_sample_valid <= 1'b0;
        end
    end

endmodule // sfsat_rx_end

// file: sim/sfsat_chk.sv
// sfsat_chk: concurrent checks on the link between the two ends.
// assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module sfsat_chk
    import sfsat_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_scramble_enable,
    input  wire logic       i_align_monitor_enable,
    input  wire logic       sync_req,
    input  wire logic       frame_valid,
    input  wire logic [7:0] oct1,
    input  wire logic       k1,
    input  wire logic [7:0] oct2,
    input  wire logic       k2
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic comma;
    logic sub;
    logic m1;
    logic m2;
    assign comma = frame_valid && k1 && k2 && oct1 == SYM_K28_5
                   && oct2 == SYM_K28_5;
    assign sub = frame_valid && !k1 && k2;
    assign m1 = i_align_monitor_enable && !i_scramble_enable;
    assign m2 = i_align_monitor_enable && i_scramble_enable;
    // ****************************************************************
    // assertions; mode held 4 clocks covers the two input flops
    // ****************************************************************
    AST_PRE_START: assert property (
        $rose(sync_req) ##1 sync_req |-> ##3 comma)
        else $error("comma frame missing after request");
    AST_PRE_HOLD: assert property (
        sync_req [*5] |-> comma)
        else $error("comma stream broken while requested");
    AST_PRE_END: assert property (
        sync_req [*5] ##1 !sync_req |-> comma [*3] ##1 !comma)
        else $error("preamble end timing wrong");
    AST_K1_COMMA: assert property (
        frame_valid && k1 |-> comma)
        else $error("control symbol in first group");
    AST_K2_CODE: assert property (
        sub |-> oct2 == SYM_K28_7)
        else $error("wrong control symbol in second group");
    AST_MON_OFF: assert property (
        (!i_align_monitor_enable) [*4] |-> !sub)
        else $error("substitution with monitor off");
    AST_M1_NOT_TWICE: assert property (
        m1 [*4] ##0 sub ##1 frame_valid |-> !sub)
        else $error("substitution in two frames running");
    AST_M1_REPEAT: assert property (
        m1 [*4] ##0 (frame_valid && !k1 && !k2) ##1
        (frame_valid && !k1 && oct2 == $past(oct2)) |-> k2)
        else $error("repeated second group not substituted");
    AST_M2_FIXED: assert property (
        m2 [*4] ##0 (frame_valid && !k1 && oct2 == SYM_D28_7) |-> k2)
        else $error("fixed octet not substituted");
    cover property (m1 && sub);
    cover property (m2 && sub);
    cover property ($fell(sync_req));
endmodule // sfsat_chk

// file: sim/sfsat_tb.sv
// sfsat_tb: both ends joined by the link, checked against a model.
// assumes the design package and link interface are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) chk_t(32'(a), 32'(b))
module sfsat_tb;
    import sfsat_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    logic [15:0] smp = 16'h0000;
    logic        sv = 0, scr = 0, mon = 0, rlo = 0, rhi = 0;
    logic        plo = 0, phi = 0, rsy = 0, urdy = 1, chk_rx = 0;
    logic        sr, osv, osyn;
    logic [1:0]  pll;
    logic [15:0] osmp, w, pf, pw = 16'hFFFF;
    logic [7:0]  lo2 = 8'h00;
    logic [2:0]  pm = 3'h0, lpm = 3'h0;
    logic [15:0] qw[$], qr[$];
    int          n_fail = 0, cmp_count = 0, cyc = 0;
    sfsat_link_if lk();
    sfsat_tx_end sfsat_tx_end_i (.i_clk(clk), .i_rst(rst), .i_sample(smp),
        .i_sample_valid(sv), .o_sample_ready(sr), .i_scramble_enable(scr),
        .i_align_monitor_enable(mon), .i_rate_range_sel_lo(rlo),
        .i_rate_range_sel_hi(rhi), .i_test_pattern_sel_lo(plo),
        .i_test_pattern_sel_hi(phi), .o_pll_range(pll), .link(lk));
    sfsat_rx_end sfsat_rx_end_i (.i_clk(clk), .i_rst(rst),
        .i_scramble_enable(scr), .i_align_monitor_enable(mon),
        .i_resync(rsy), .i_user_ready(urdy), .o_sample(osmp),
        .o_sample_valid(osv), .o_synced(osyn), .link(lk));
    sfsat_chk sfsat_chk_i (.i_clk(clk), .i_rst(rst),
        .i_scramble_enable(scr), .i_align_monitor_enable(mon),
        .sync_req(lk.sync_req), .frame_valid(lk.frame_valid),
        .oct1(lk.oct1), .k1(lk.k1), .oct2(lk.oct2), .k2(lk.k2));
    initial
    begin
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    task automatic chk_t(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // t 0/1: prbs 11/15 from last frame, t 2: scramble d
    function automatic logic [15:0] f(input logic [15:0] d,
                                      input logic [15:0] p, input int t);
        logic [15:0] s;
        logic [15:0] o;
        s = p;
        for (int i = 15; i >= 0; i--)
        begin
            o[i] = (t == 2 ? d[i] : 1'b0)
                   ^ (t == 0 ? s[10] ^ s[8] : s[14] ^ s[13]);
            s = {s[14:0], o[i]};
        end
        return o;
    endfunction
    // ****************************************************************
    // link and output monitor
    // ****************************************************************
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail++;
            stop_test();
        end
        if (!rst && sv && sr)
        begin
            qw.push_back(smp);
            qr.push_back(smp);
        end
        if (lk.frame_valid && !lk.k1 && pm != 3'h4)
        begin
            w = {lk.oct1, lk.oct2};
            if (pm == 3'h0)
            begin
                if (lk.k2)
                    w[7:0] = scr ? SYM_D28_7 : lo2;
                `CHK(w, scr ? f(qw[0], pw, 2) : qw[0]);
                if (scr)
                    pw = w;
                lo2 = w[7:0];
                void'(qw.pop_front());
            end
            else if (pm == 3'h1)
                `CHK(w, {SYM_D21_5, SYM_D21_5});
            else if (lpm == pm)
                `CHK(w, f(16'h0000, pf, int'(pm[0])));
            pf = w;
            lpm = pm;
        end
        if (chk_rx && osv && urdy)
        begin
            `CHK(osmp, qr[0]);
            void'(qr.pop_front());
        end
    end
    task automatic resync();
        rsy <= 1;
        @(posedge clk);
        rsy <= 0;
        while (lk.sync_req !== 1'b1)
            @(posedge clk);
        while (osyn !== 1'b1)
            @(posedge clk);
    endtask
    task automatic drain();
        sv <= 0;
        while (qw.size() != 0)
            @(posedge clk);
        repeat (10) @(posedge clk);
    endtask
    task automatic push(input logic rep);
        smp <= {8'($urandom), rep ? smp[7:0] : 8'($urandom)};
        sv <= 1;
        do
            @(posedge clk);
        while (sr !== 1'b1);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h0B0FB18F));
        repeat (12) @(posedge clk);
        rst <= 0;
        while (osyn !== 1'b1)
            @(posedge clk);
        for (int r = 0; r < 4; r++)
        begin
            {rhi, rlo} <= r[1:0];
            repeat (4) @(posedge clk);
            `CHK(pll, r[1] ? (r[0] ? 2 : 1) : 0);
        end
        for (int p = 1; p < 4; p++)
        begin
            pm <= 3'h4;
            {phi, plo} <= p[1:0];
            repeat (4) @(posedge clk);
            pm <= 3'(p);
            sv <= (p == 1);
            repeat (20) @(posedge clk);
            if (p == 1)
            begin
                @(negedge clk);
                `CHK(sr, 1'b0);
                `CHK(qw.size(), 2);
                @(posedge clk);
                sv <= 0;
            end
        end
        // stall while the buffer still holds two words
        urdy <= 0;
        repeat (3) @(posedge clk);
        pm <= 3'h4;
        {phi, plo} <= 2'h0;
        repeat (6) @(posedge clk);
        pm <= 3'h0;
        urdy <= 1;
        drain();
        for (int m = 0; m < 4; m++)
        begin
            {mon, scr} <= m[1:0];
            chk_rx <= 0;
            resync();
            qr.delete();
            chk_rx <= 1;
            repeat (150)
            begin
                push(1'($urandom_range(1, 0)));
                if ($urandom_range(3, 0) == 0)
                begin
                    sv <= 0;
                    @(posedge clk);
                end
            end
            drain();
            `CHK(qr.size(), 0);
        end
        stop_test();
    end
endmodule // sfsat_tb
